/* hdl/oms_pkg.sv */
// Shared types and constants for the operating-mode select block
package oms_pkg;
    localparam int OMS_ADDR_W = 16;
    localparam int OMS_DATA_W = 16;
    localparam int OMS_BYTE_W = 8;

    // Mode codes, ordered {debug pin, select b, select a}
    typedef enum logic [2:0] {
        OMS_SPEC_SC     = 3'b000,
        OMS_SPEC_NAR    = 3'b001,
        OMS_SPEC_PERIPH = 3'b010,
        OMS_SPEC_WIDE   = 3'b011,
        OMS_NORM_SC     = 3'b100,
        OMS_NORM_NAR    = 3'b101,
        OMS_RESERVED    = 3'b110,
        OMS_NORM_WIDE   = 3'b111
    } oms_mode_t;

    // Port pin usage
    typedef enum logic [1:0] {
        OMS_PF_GPIO      = 2'b00,
        OMS_PF_ADDR      = 2'b01,
        OMS_PF_ADDR_DATA = 2'b10
    } oms_port_func_t;

    typedef struct packed {
        logic special_mode_n_bit;
        logic mode_select_b;
        logic mode_select_a;
    } oms_mode_bits_t;

    typedef struct packed {
        logic write;
        logic [OMS_ADDR_W-1:0] addr;
        logic [OMS_DATA_W-1:0] data;
    } oms_word_req_t;

    typedef struct packed {
        logic valid;
        logic narrow;
        logic write;
        logic [OMS_ADDR_W-1:0] addr;
        logic [OMS_DATA_W-1:0] data;
    } oms_bus_cyc_t;

    localparam oms_mode_bits_t OMS_MODE_BITS_RST = 3'h0;
    localparam logic [OMS_ADDR_W-1:0] OMS_ADDR_STEP = 16'h0001;
    localparam logic [OMS_BYTE_W-1:0] OMS_BYTE_ZERO = 8'h00;
endpackage

/* hdl/oms_bus_seq.sv */
// Word-to-bus-cycle sequencer for the multiplexed external bus
`timescale 1ns/1ps
module oms_bus_seq
    import oms_pkg::*;
#(
    parameter int DATA_W = OMS_DATA_W
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic bus_en_in,
    input wire logic narrow_in,
    input wire logic req_valid_in,
    input wire oms_word_req_t req_in,
    output logic req_ready_out,
    output oms_bus_cyc_t cyc_out
);
    // Byte split below assumes a word of exactly two bytes; refuse anything else at elaboration
    if (DATA_W != 2 * OMS_BYTE_W)
    begin : g_width_check
        $error("oms_bus_seq: DATA_W must be two bytes");
    end

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_WIDE = 2'b01,
        SQ_HI   = 2'b10,
        SQ_LO   = 2'b11
    } oms_seq_state_t;

    oms_seq_state_t state_reg;
    oms_bus_cyc_t cyc_reg;
    logic ready_reg;
    logic [OMS_BYTE_W-1:0] lo_hold_reg;
    wire logic take = req_valid_in && ready_reg && state_reg == SQ_IDLE;

    // Narrow words go out high byte then low byte at address plus one
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= SQ_IDLE;
            cyc_reg <= '0;
            ready_reg <= 1'b0;
            lo_hold_reg <= OMS_BYTE_ZERO;
        end
        else
        begin
            unique case (state_reg)
                SQ_IDLE:
                begin
                    ready_reg <= bus_en_in && !take;
                    cyc_reg.valid <= take;
                    if (take)
                    begin
                        cyc_reg.narrow <= narrow_in;
                        cyc_reg.write <= req_in.write;
                        cyc_reg.addr <= req_in.addr;
                        lo_hold_reg <= req_in.data[OMS_BYTE_W-1:0];
                        cyc_reg.data <= narrow_in ? {OMS_BYTE_ZERO, req_in.data[DATA_W-1:OMS_BYTE_W]} : req_in.data;
                        state_reg <= narrow_in ? SQ_HI : SQ_WIDE;
                    end
                end
                SQ_HI:
                begin
                    cyc_reg.addr <= cyc_reg.addr + OMS_ADDR_STEP;
                    cyc_reg.data <= {OMS_BYTE_ZERO, lo_hold_reg};
                    state_reg <= SQ_LO;
                end
                SQ_WIDE, SQ_LO:
                begin
                    cyc_reg.valid <= 1'b0;
                    ready_reg <= bus_en_in;
                    state_reg <= SQ_IDLE;
                end
            endcase
        end
    end

    assign req_ready_out = ready_reg;
    assign cyc_out = cyc_reg;

    property p_narrow_pair;
        @(posedge clk_in) disable iff (!rst_b_in)
        take && narrow_in |=> cyc_reg.valid && cyc_reg.data[7:0] == $past(req_in.data[15:8])
            ##1 cyc_reg.valid && cyc_reg.addr == $past(cyc_reg.addr) + OMS_ADDR_STEP ##1 !cyc_reg.valid;
    endproperty
    a_narrow_pair: assert property (p_narrow_pair) else $error("narrow word not split high then low");

    property p_wide_single;
        @(posedge clk_in) disable iff (!rst_b_in)
        take && !narrow_in |=> cyc_reg.valid && !cyc_reg.narrow ##1 !cyc_reg.valid;
    endproperty
    a_wide_single: assert property (p_wide_single) else $error("wide word not a single cycle");
endmodule // oms_bus_seq

/* hdl/oms_top.sv */
// Operating-mode select: reset-time mode latch, mode writes, decode and bus steering
//
// Overview of operation
// - The mode comes from the debug pin and the two select pins as they stand during reset.
// - At reset release the three pin levels are latched into the readable mode bits.
// - Codes 100/101/111 are normal single/narrow/wide, 110 acts as peripheral, 000/001/010/011 are special ones.
// - Single-chip modes have no external bus and both ports are general-purpose I/O.
// - Wide modes and special peripheral use ports A and B as a 16-bit multiplexed address/data bus.
// - Narrow modes drive a 16-bit address on A and B with port A alone carrying 8-bit data.
// - In narrow modes a word goes out as high byte then low byte, the address stepping on the second.
// - Normal modes protect certain control bits; special modes open them for test and emulation.
// - Special single-chip mode leaves reset with background debug already active.
// - Special peripheral mode holds the processor and lets an external master reach peripherals.
// - Peripheral mode is neither entered nor left except through reset.
// - Software may switch modes only in a limited way by writing the latched mode bits.
// - The special-mode bit is writable only while it is zero, and the first write is ignored.
// - Select bits are writable once when the special bit is one, else anytime but the first, never to peripheral.
`timescale 1ns/1ps
module oms_top
    import oms_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic debug_mode_pin_in,
    input wire logic mode_select_b_in,
    input wire logic mode_select_a_in,
    input wire logic mode_wr_in,
    input wire oms_mode_bits_t mode_wr_data_in,
    input wire logic background_debug_go_in,
    input wire logic background_debug_exit_in,
    input wire logic ext_req_valid_in,
    input wire oms_word_req_t ext_req_in,
    output logic ext_req_ready_out,
    output oms_bus_cyc_t ext_cyc_out,
    output oms_mode_bits_t mode_bits_out,
    output oms_mode_t mode_out,
    output oms_port_func_t port_a_func_out,
    output oms_port_func_t port_b_func_out,
    output logic protect_en_out,
    output logic cpu_hold_out,
    output logic background_debug_active_out,
    output logic mode_valid_out
);
    // Pin synchronisers; no reset so pin levels flow through while reset is held
    oms_mode_bits_t pin_meta_reg;
    oms_mode_bits_t pin_sync_reg;

    always_ff @(posedge clk_in)
    begin
        pin_meta_reg <= {debug_mode_pin_in, mode_select_b_in, mode_select_a_in};
        pin_sync_reg <= pin_meta_reg;
    end

    // Mode state
    oms_mode_bits_t mode_bits_reg;
    logic latched_reg;
    logic wr_seen_reg;
    oms_mode_t mode_reg;
    oms_port_func_t port_a_reg;
    oms_port_func_t port_b_reg;
    logic protect_reg;
    logic cpu_hold_reg;
    logic background_debug_reg;

    // Write qualification; refused while peripheral so that mode cannot be left
    wire logic spec_n_cur = mode_bits_reg.special_mode_n_bit;
    wire logic periph_cur = mode_bits_reg.mode_select_b && !mode_bits_reg.mode_select_a;
    wire logic wr_take = mode_wr_in && latched_reg && !periph_cur;
    wire logic spec_n_ok = wr_take && !spec_n_cur && wr_seen_reg;
    wire logic sel_base_ok = wr_take && (spec_n_cur ? !wr_seen_reg : wr_seen_reg);
    wire logic sel_bad = mode_wr_data_in.mode_select_b && !mode_wr_data_in.mode_select_a;
    wire logic sel_ok = sel_base_ok && !sel_bad;

    // Next mode bits: pins at the first edge after reset, then permitted writes only
    oms_mode_bits_t wr_bits;
    oms_mode_bits_t mode_bits_next;
    assign wr_bits.special_mode_n_bit = spec_n_ok ? mode_wr_data_in.special_mode_n_bit : spec_n_cur;
    assign wr_bits.mode_select_b = sel_ok ? mode_wr_data_in.mode_select_b : mode_bits_reg.mode_select_b;
    assign wr_bits.mode_select_a = sel_ok ? mode_wr_data_in.mode_select_a : mode_bits_reg.mode_select_a;
    assign mode_bits_next = latched_reg ? wr_bits : pin_sync_reg;

    // Decode from next bits so ports follow one cycle after the write
    wire oms_mode_t code_next = oms_mode_t'(mode_bits_next);
    wire oms_mode_t mode_next = (code_next == OMS_RESERVED) ? OMS_SPEC_PERIPH : code_next;
    wire logic sc_next = !mode_bits_next.mode_select_b && !mode_bits_next.mode_select_a;
    wire logic nar_next = !mode_bits_next.mode_select_b && mode_bits_next.mode_select_a;
    wire logic periph_next = mode_next == OMS_SPEC_PERIPH;
    wire oms_port_func_t port_a_next = sc_next ? OMS_PF_GPIO : OMS_PF_ADDR_DATA;
    wire oms_port_func_t port_b_next = sc_next ? OMS_PF_GPIO
                                     : (nar_next ? OMS_PF_ADDR : OMS_PF_ADDR_DATA);
    wire logic protect_next = mode_bits_next.special_mode_n_bit;

    // Debug goes active out of reset in special single chip; otherwise by external command outside peripheral mode
    wire logic background_debug_next = !latched_reg ? (mode_next == OMS_SPEC_SC)
        : (background_debug_reg || (background_debug_go_in && !periph_next)) && !background_debug_exit_in;

    // Mode register and latch
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_bits_reg <= OMS_MODE_BITS_RST;
            latched_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
        end
        else
        begin
            mode_bits_reg <= mode_bits_next;
            latched_reg <= 1'b1;
            wr_seen_reg <= wr_seen_reg || wr_take;
        end
    end

    // Decoded configuration; CPU held until the mode is known
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_reg <= OMS_SPEC_SC;
            port_a_reg <= OMS_PF_GPIO;
            port_b_reg <= OMS_PF_GPIO;
            protect_reg <= 1'b1;
            cpu_hold_reg <= 1'b1;
            background_debug_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            port_a_reg <= port_a_next;
            port_b_reg <= port_b_next;
            protect_reg <= protect_next;
            cpu_hold_reg <= periph_next;
            background_debug_reg <= background_debug_next;
        end
    end

    // Device masters the bus only in expanded modes; never in single chip or peripheral
    wire logic bus_en = latched_reg && port_a_reg == OMS_PF_ADDR_DATA && !cpu_hold_reg;
    wire logic narrow_now = port_b_reg == OMS_PF_ADDR;

    oms_bus_seq #(
        .DATA_W(OMS_DATA_W)
    ) u_seq (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bus_en_in(bus_en),
        .narrow_in(narrow_now),
        .req_valid_in(ext_req_valid_in),
        .req_in(ext_req_in),
        .req_ready_out(ext_req_ready_out),
        .cyc_out(ext_cyc_out)
    );

    assign mode_bits_out = mode_bits_reg;
    assign mode_out = mode_reg;
    assign port_a_func_out = port_a_reg;
    assign port_b_func_out = port_b_reg;
    assign protect_en_out = protect_reg;
    assign cpu_hold_out = cpu_hold_reg;
    assign background_debug_active_out = background_debug_reg;
    assign mode_valid_out = latched_reg;

    // Checks
    property p_latch_pins;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(latched_reg) |-> mode_bits_reg == $past(pin_sync_reg, 1);
    endproperty
    a_latch_pins: assert property (p_latch_pins) else $error("pins not latched at reset release");

    property p_pin_to_mode;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(latched_reg) && $past(pin_sync_reg) == 3'h5 |-> mode_reg == OMS_NORM_NAR;
    endproperty
    a_pin_to_mode: assert property (p_pin_to_mode) else $error("pin code not decoded");

    property p_reserved;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg && mode_bits_reg == 3'h6 |-> mode_reg == OMS_SPEC_PERIPH && cpu_hold_reg;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not forced to peripheral");

    property p_single_chip;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg && (mode_reg == OMS_SPEC_SC || mode_reg == OMS_NORM_SC)
            |-> port_a_reg == OMS_PF_GPIO && port_b_reg == OMS_PF_GPIO ##1 !ext_req_ready_out;
    endproperty
    a_single_chip: assert property (p_single_chip) else $error("single chip exposes a bus");

    property p_narrow_ports;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg && (mode_reg == OMS_SPEC_NAR || mode_reg == OMS_NORM_NAR)
            |-> port_a_reg == OMS_PF_ADDR_DATA && port_b_reg == OMS_PF_ADDR;
    endproperty
    a_narrow_ports: assert property (p_narrow_ports) else $error("narrow port use wrong");

    property p_protect;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg |-> protect_reg == mode_bits_reg.special_mode_n_bit;
    endproperty
    a_protect: assert property (p_protect) else $error("protection not tied to mode");

    property p_debug_sc;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(latched_reg) && mode_reg == OMS_SPEC_SC |-> background_debug_reg;
    endproperty
    a_debug_sc: assert property (p_debug_sc) else $error("debug not active out of reset");

    property p_periph_fixed;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg && $past(latched_reg) |-> cpu_hold_reg == $past(cpu_hold_reg);
    endproperty
    a_periph_fixed: assert property (p_periph_fixed) else $error("peripheral mode changed at run time");

    property p_first_ignored;
        @(posedge clk_in) disable iff (!rst_b_in)
        mode_wr_in && latched_reg && !wr_seen_reg && !mode_bits_reg.special_mode_n_bit |=> $stable(mode_bits_reg);
    endproperty
    a_first_ignored: assert property (p_first_ignored) else $error("first special write took effect");

    property p_norm_once;
        @(posedge clk_in) disable iff (!rst_b_in)
        mode_wr_in && wr_seen_reg && mode_bits_reg.special_mode_n_bit |=> $stable(mode_bits_reg);
    endproperty
    a_norm_once: assert property (p_norm_once) else $error("normal mode bits written twice");

    property p_hold_mode;
        @(posedge clk_in) disable iff (!rst_b_in)
        latched_reg && !mode_wr_in |=> $stable(mode_bits_reg) && $stable(mode_reg);
    endproperty
    a_hold_mode: assert property (p_hold_mode) else $error("mode changed without a write");
endmodule // oms_top

/* test/oms_ext_mem.sv */
// Behavioural external memory on the multiplexed bus that logs every bus cycle
`timescale 1ns/1ps
module oms_ext_mem
    import oms_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire oms_bus_cyc_t cyc_in
);
    oms_bus_cyc_t log_q[$];

    // Log each valid cycle; narrow halves arrive as separate entries
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            log_q.delete();
        else if (cyc_in.valid === 1'b1)
        begin
            log_q.push_back(cyc_in);
        end
    end
endmodule // oms_ext_mem

/* test/tb_oms_top.sv */
// Self-checking bench for the operating-mode select block
`timescale 1ns/1ps
module tb_oms_top
    import oms_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [2:0] pins = 3'h4;
    logic mode_wr_in = 1'b0;
    oms_mode_bits_t mode_wr_data_in = 3'h0;
    logic go_in = 1'b0;
    logic exit_in = 1'b0;
    logic ext_req_valid_in = 1'b0;
    oms_word_req_t ext_req_in = '0;
    logic ext_req_ready_out;
    oms_bus_cyc_t ext_cyc_out;
    oms_mode_bits_t mode_bits_out;
    oms_mode_t mode_out;
    oms_port_func_t port_a_func_out;
    oms_port_func_t port_b_func_out;
    logic protect_en_out;
    logic cpu_hold_out;
    logic dbg_active_out;
    logic mode_valid_out;
    logic [8:0] got_state;
    int fail_count = 0;
    int checks_done = 0;

    // Decoded outputs gathered for one comparison
    assign got_state = {mode_out, port_a_func_out, port_b_func_out, protect_en_out, cpu_hold_out};

    oms_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .debug_mode_pin_in(pins[2]), .mode_select_b_in(pins[1]),
        .mode_select_a_in(pins[0]), .mode_wr_in(mode_wr_in), .mode_wr_data_in(mode_wr_data_in),
        .background_debug_go_in(go_in), .background_debug_exit_in(exit_in), .ext_req_valid_in(ext_req_valid_in),
        .ext_req_in(ext_req_in), .ext_req_ready_out(ext_req_ready_out), .ext_cyc_out(ext_cyc_out),
        .mode_bits_out(mode_bits_out), .mode_out(mode_out), .port_a_func_out(port_a_func_out),
        .port_b_func_out(port_b_func_out), .protect_en_out(protect_en_out), .cpu_hold_out(cpu_hold_out),
        .background_debug_active_out(dbg_active_out), .mode_valid_out(mode_valid_out));

    oms_ext_mem mem (.clk_in(clk_in), .rst_b_in(rst_b_in), .cyc_in(ext_cyc_out));

    // 10 MHz clock
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end

    // Expected decode of a mode code: reserved 110 behaves as peripheral
    function automatic logic [8:0] exp_state(input logic [2:0] c);
        logic [2:0] m;
        oms_port_func_t pa;
        oms_port_func_t pb;
        m = (c == 3'h6) ? 3'h2 : c;
        pa = (m[1:0] == 2'h0) ? OMS_PF_GPIO : OMS_PF_ADDR_DATA;
        pb = (m[1:0] == 2'h0) ? OMS_PF_GPIO : ((m[1:0] == 2'h1) ? OMS_PF_ADDR : OMS_PF_ADDR_DATA);
        return {m, pa, pb, c[2], m == 3'h2};
    endfunction

    task automatic check_val(input logic [34:0] got, input logic [34:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Reset with pins held at code c, then check what was latched
    task automatic do_reset(input logic [2:0] c);
        @(negedge clk_in);
        pins = c;
        rst_b_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        check_val(mode_bits_out, c);
        check_val(got_state, exp_state(c));
        check_val(dbg_active_out, c == 3'h0);
        check_val(mode_valid_out, 1'b1);
        @(negedge clk_in);
        check_val(ext_req_ready_out, c[1:0] != 2'h0 && c[1:0] != 2'h2);
    endtask

    // One mode write, then compare bits and decoded outputs
    task automatic mode_write(input logic [2:0] d, input logic [2:0] exp);
        mode_wr_in = 1'b1;
        mode_wr_data_in = d;
        @(negedge clk_in);
        mode_wr_in = 1'b0;
        @(negedge clk_in);
        check_val(mode_bits_out, exp);
        check_val(got_state, exp_state(exp));
    endtask

    // Offer one word, wait bounded for it to be taken; valid is left up for chaining
    task automatic send_word(input logic [15:0] a, input logic [15:0] d);
        int i;
        ext_req_in = '{1'b1, a, d};
        ext_req_valid_in = 1'b1;
        for (i = 0; i < 20 && ext_req_ready_out !== 1'b1; i++)
            @(negedge clk_in);
        if (i == 20)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, ext_req_ready_out, 1'b1);
            fail_count++;
            complete_run();
        end
        @(negedge clk_in);
    endtask

    task automatic test_reset_codes();
        for (int c = 0; c < 8; c++)
            do_reset(c[2:0]);
        $display("test_reset_codes done");
    endtask

    task automatic test_bus_wide();
        int n;
        do_reset(3'h7);
        n = mem.log_q.size();
        send_word(16'h1234, 16'hA55A);
        send_word(16'h2000, 16'h0F0F);
        ext_req_valid_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check_val(mem.log_q.size() - n, 2);
        check_val(mem.log_q[n], {3'h5, 16'h1234, 16'hA55A});
        check_val(mem.log_q[n + 1], {3'h5, 16'h2000, 16'h0F0F});
        $display("test_bus_wide done");
    endtask

    task automatic test_bus_narrow();
        int n;
        do_reset(3'h1);
        n = mem.log_q.size();
        send_word(16'hFFFF, 16'hBEEF);
        ext_req_valid_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check_val(mem.log_q.size() - n, 2);
        check_val(mem.log_q[n], {3'h7, 16'hFFFF, 16'h00BE});
        check_val(mem.log_q[n + 1], {3'h7, 16'h0000, 16'h00EF});
        $display("test_bus_narrow done");
    endtask

    // No bus cycles in single-chip or peripheral modes
    task automatic test_bus_refused();
        logic [2:0] codes [2];
        codes = '{3'h4, 3'h2};
        foreach (codes[k])
        begin
            do_reset(codes[k]);
            ext_req_in = '{1'b1, 16'h0100, 16'h1111};
            ext_req_valid_in = 1'b1;
            repeat (8) @(negedge clk_in);
            ext_req_valid_in = 1'b0;
            check_val(ext_req_ready_out, 1'b0);
            check_val(mem.log_q.size(), 0);
        end
        $display("test_bus_refused done");
    endtask

    task automatic test_mode_writes();
        do_reset(3'h1);
        mode_write(3'h3, 3'h1);
        mode_write(3'h2, 3'h1);
        mode_write(3'h3, 3'h3);
        mode_write(3'h5, 3'h5);
        do_reset(3'h5);
        mode_write(3'h7, 3'h7);
        mode_write(3'h4, 3'h7);
        mode_write(3'h1, 3'h7);
        do_reset(3'h2);
        mode_write(3'h3, 3'h2);
        do_reset(3'h6);
        mode_write(3'h7, 3'h6);
        $display("test_mode_writes done");
    endtask

    task automatic debug_pulse(input logic go, input logic exp);
        go_in = go;
        exit_in = !go;
        @(negedge clk_in);
        go_in = 1'b0;
        exit_in = 1'b0;
        @(negedge clk_in);
        check_val(dbg_active_out, exp);
    endtask

    task automatic test_debug();
        do_reset(3'h4);
        debug_pulse(1'b1, 1'b1);
        debug_pulse(1'b0, 1'b0);
        do_reset(3'h0);
        debug_pulse(1'b0, 1'b0);
        do_reset(3'h2);
        debug_pulse(1'b1, 1'b0);
        $display("test_debug done");
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk_in);
        test_reset_codes();
        test_bus_wide();
        test_bus_narrow();
        test_bus_refused();
        test_mode_writes();
        test_debug();
        complete_run();
    end
endmodule // tb_oms_top
